/* hdl/sbc_event_capture_sleep_guard.v */
// event capture flags, global summary and sleep entry guard of the basis chip
// assumes a register port from the serial decoder on sys_clk, event pulses from
// on-chip monitors on sys_clk, and an asynchronous wake pin
//
// How it works
// - sleep ends only when an event flag has been captured
// - can and wake pin wakes are regular; everything else is diagnostic
// - sleep request with all regular wake enables off gives a system reset
// - sleep command 001 with a regular wake enabled and any flag pending goes to reset mode
// - sleep lockout set: sleep command raises serial fault, no sleep
// - host clears a flag by writing one; zero leaves it
// - global summary bits 0..3 flag system, supply, transceiver, wake groups
// - battery start flag on bit 4 when leaving off mode
// - overheat warning sets system bit 2
// - serial interface failure sets system bit 1
// - watchdog failure sets system bit 0
// - supply bits: sensor high 2, sensor low 1, controller low 0
// - selective frame detection error sets transceiver bit 5
// - bus silence sets transceiver bit 4; reads zero while bus active
// - transceiver deactivation sets transceiver bit 1
// - can wake while offline sets transceiver bit 0
// - wake pin rise sets bit 1, fall sets bit 0
// - system enable bit 2 gates overheat warning capture
// - flags set only when enabled; start, watchdog, frame error always
// - offline transceiver with controller supply on and any flag pending drives receive pin low
// - event in sleep turns supply on, goes to standby through reset
`timescale 1ns/1ps
`include "sbc_event_defines.vh"

module sbc_event_capture_sleep_guard #(
   parameter HAS_SENSOR_SUPPLY = 1                  // 0 on variants without sensor supply
) (
   input  wire       sys_clk,                       // 10 MHz internal clock
   input  wire       rst_b,                         // power-on reset, active low
   input  wire [6:0] reg_addr,                      // register address
   input  wire       reg_wr,                        // one-cycle write strobe
   input  wire [7:0] reg_wdata,                     // write data
   output reg  [7:0] reg_rdata_ff,                  // read data, one cycle after address
   input  wire       mode_cmd_valid,                // one-cycle operating mode command strobe
   input  wire [2:0] operating_mode_command,        // operating mode command code
   input  wire       sleep_lockout_config,          // nonvolatile sleep lockout
   input  wire       off_mode_exit,                 // pulse: left off mode after power-up
   input  wire       overheat_event,                // pulse: warning threshold passed
   input  wire       serial_fail_event,             // pulse: serial interface failure
   input  wire       watchdog_fail_event,           // pulse: watchdog failure
   input  wire       sensor_high_event,             // pulse: sensor supply overvoltage
   input  wire       sensor_low_event,              // pulse: sensor supply undervoltage
   input  wire       ctrl_low_event,                // pulse: controller supply undervoltage
   input  wire       frame_error_event,             // pulse: selective frame detect error
   input  wire       silence_event,                 // pulse: bus silence timeout
   input  wire       bus_active,                    // level: bus activity seen
   input  wire       trx_deact_event,               // pulse: transceiver deactivated
   input  wire       can_wake_event,                // pulse: can wake-up detected
   input  wire       trx_offline,                   // level: transceiver offline
   input  wire       wake_pin,                      // asynchronous wake pin level
   output wire       rxd_force_low,                 // receive pin driven low for event
   output reg        sleep_mode_ff,                 // level: in sleep mode
   output reg        ctrl_supply_on_ff,             // level: controller supply enabled
   output reg        reset_mode_req_ff,             // pulse: go to reset mode
   output reg        system_reset_req_ff            // pulse: system reset
);

   // =====================================================================
   // registers
   // =====================================================================
   reg  [7:0] sys_en_ff;                            // system capture enables
   reg  [7:0] sup_en_ff;                            // supply capture enables
   reg  [7:0] trx_en_ff;                            // transceiver capture enables
   reg  [7:0] wake_en_ff;                           // wake pin capture enables
   reg  [7:0] sys_flags_ff;                         // system event flags
   reg  [7:0] sup_flags_ff;                         // supply event flags
   reg  [7:0] trx_flags_ff;                         // transceiver event flags
   reg  [7:0] wake_flags_ff;                        // wake pin event flags
   reg        wake_sync1_ff;                        // wake pin synchroniser stage 1
   reg        wake_sync2_ff;                        // wake pin synchroniser stage 2
   reg        wake_prev_ff;                         // last synchronised wake level

   wire       sleep_cmd;                            // sleep command seen
   wire       regular_enabled;                      // any regular wake source enabled
   wire       any_pending;                          // any flag set
   wire       lockout_fault;                        // sleep command refused by lockout
   wire       wake_rise;                            // synchronised rising edge
   wire       wake_fall;                            // synchronised falling edge
   wire [7:0] sup_valid;                            // implemented supply bits
   wire [3:0] global_summary;                       // group pending bits
   reg  [7:0] sys_set;                              // system set terms
   reg  [7:0] sup_set;                              // supply set terms
   reg  [7:0] trx_set;                              // transceiver set terms
   reg  [7:0] wake_set;                             // wake pin set terms
   reg  [7:0] nxt_rdata;                            // read mux

   // write-one-to-clear with set winning over a clear in the same cycle
   function [7:0] w1c_next;
      input [7:0] flags;
      input       hit;
      input [7:0] wdata;
      input [7:0] set;
      begin
         w1c_next = (flags & ~(hit ? wdata : 8'h00)) | set;
      end
   endfunction

   // =====================================================================
   // wake pin synchroniser and edge detection
   // =====================================================================
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_sync1_ff <= 1'b0;
         wake_sync2_ff <= 1'b0;
         wake_prev_ff  <= 1'b0;
      end else begin
         wake_sync1_ff <= wake_pin;
         wake_sync2_ff <= wake_sync1_ff;
         wake_prev_ff  <= wake_sync2_ff;
      end
   end

   assign wake_rise = wake_sync2_ff & ~wake_prev_ff;
   assign wake_fall = ~wake_sync2_ff & wake_prev_ff;

   // =====================================================================
   // sleep command decisions
   // =====================================================================
   // lockout is checked first so a locked part never resets on a stray sleep command
   assign sleep_cmd       = mode_cmd_valid & (operating_mode_command == `MODE_CMD_SLEEP);
   assign lockout_fault   = sleep_cmd & sleep_lockout_config;
   // only can and wake pin sources count as regular wakes
   assign regular_enabled = trx_en_ff[`BIT_CAN_WAKE] | wake_en_ff[`BIT_WAKE_RISE] |
                            wake_en_ff[`BIT_WAKE_FALL];
   assign sup_valid       = HAS_SENSOR_SUPPLY ? 8'h07 : 8'h01;
   assign global_summary  = {|wake_flags_ff, |trx_flags_ff,
                             |sup_flags_ff, |sys_flags_ff};
   assign any_pending     = |global_summary;

   // =====================================================================
   // set terms, gated by capture enables except start, watchdog and frame error
   // =====================================================================
   always @* begin
      sys_set  = 8'h00;
      sup_set  = 8'h00;
      trx_set  = 8'h00;
      wake_set = 8'h00;
      sys_set[`BIT_BATTERY_START] = off_mode_exit;
      // overheat and serial fault are not captured while asleep
      sys_set[`BIT_OVERHEAT]      = overheat_event & sys_en_ff[`BIT_OVERHEAT] &
                                    ~sleep_mode_ff;
      sys_set[`BIT_SERIAL_FAULT]  = (serial_fail_event | lockout_fault) &
                                    sys_en_ff[`BIT_SERIAL_FAULT] & ~sleep_mode_ff;
      sys_set[`BIT_WATCHDOG]      = watchdog_fail_event;
      sup_set[`BIT_SENSOR_HIGH]   = sensor_high_event & sup_en_ff[`BIT_SENSOR_HIGH];
      sup_set[`BIT_SENSOR_LOW]    = sensor_low_event & sup_en_ff[`BIT_SENSOR_LOW];
      // controller supply is off in sleep so its monitor is ignored there
      sup_set[`BIT_CTRL_LOW]      = ctrl_low_event & sup_en_ff[`BIT_CTRL_LOW] &
                                    ~sleep_mode_ff;
      sup_set                     = sup_set & sup_valid;
      trx_set[`BIT_FRAME_ERROR]   = frame_error_event;
      trx_set[`BIT_BUS_SILENCE]   = silence_event & ~bus_active &
                                    trx_en_ff[`BIT_BUS_SILENCE];
      trx_set[`BIT_BUS_FAULT]     = trx_deact_event & trx_en_ff[`BIT_BUS_FAULT];
      trx_set[`BIT_CAN_WAKE]      = can_wake_event & trx_offline &
                                    trx_en_ff[`BIT_CAN_WAKE];
      wake_set[`BIT_WAKE_RISE]    = wake_rise & wake_en_ff[`BIT_WAKE_RISE];
      wake_set[`BIT_WAKE_FALL]    = wake_fall & wake_en_ff[`BIT_WAKE_FALL];
   end

   // =====================================================================
   // enable and flag registers
   // =====================================================================
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_en_ff     <= `RST_ENABLE;
         sup_en_ff     <= `RST_ENABLE;
         trx_en_ff     <= `RST_ENABLE;
         wake_en_ff    <= `RST_ENABLE;
         sys_flags_ff  <= `RST_FLAGS;
         sup_flags_ff  <= `RST_FLAGS;
         trx_flags_ff  <= `RST_FLAGS;
         wake_flags_ff <= `RST_FLAGS;
      end else begin
         if (reg_wr && reg_addr == `ADDR_SYS_ENABLE) begin
            sys_en_ff <= reg_wdata & `MASK_SYS_ENABLE;
         end
         if (reg_wr && reg_addr == `ADDR_SUP_ENABLE) begin
            sup_en_ff <= reg_wdata & `MASK_SUP_ENABLE & sup_valid;
         end
         if (reg_wr && reg_addr == `ADDR_TRX_ENABLE) begin
            trx_en_ff <= reg_wdata & `MASK_TRX_ENABLE;
         end
         if (reg_wr && reg_addr == `ADDR_WAKE_ENABLE) begin
            wake_en_ff <= reg_wdata & `MASK_WAKE_ENABLE;
         end
         sys_flags_ff  <= w1c_next(sys_flags_ff, reg_wr && reg_addr == `ADDR_SYS_FLAGS,
                                   reg_wdata, sys_set);
         sup_flags_ff  <= w1c_next(sup_flags_ff, reg_wr && reg_addr == `ADDR_SUP_FLAGS,
                                   reg_wdata, sup_set);
         // silence flag forced low while the bus is active
         trx_flags_ff  <= w1c_next(trx_flags_ff, reg_wr && reg_addr == `ADDR_TRX_FLAGS,
                                   reg_wdata, trx_set) &
                          ~(bus_active ? 8'h10 : 8'h00);
         wake_flags_ff <= w1c_next(wake_flags_ff, reg_wr && reg_addr == `ADDR_WAKE_FLAGS,
                                   reg_wdata, wake_set);
      end
   end

   // =====================================================================
   // mode control: sleep entry guard and wake from sleep
   // =====================================================================
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_mode_ff       <= 1'b0;
         ctrl_supply_on_ff   <= 1'b1;
         reset_mode_req_ff   <= 1'b0;
         system_reset_req_ff <= 1'b0;
      end else begin
         reset_mode_req_ff   <= 1'b0;
         system_reset_req_ff <= 1'b0;
         if (sleep_mode_ff) begin
            // nothing but a captured event ends sleep
            if (any_pending) begin
               sleep_mode_ff     <= 1'b0;
               ctrl_supply_on_ff <= 1'b1;
               reset_mode_req_ff <= 1'b1;
            end
         end else if (sleep_cmd && !sleep_lockout_config) begin
            if (!regular_enabled) begin
               system_reset_req_ff <= 1'b1;
            end else if (any_pending) begin
               reset_mode_req_ff <= 1'b1;
            end else begin
               sleep_mode_ff     <= 1'b1;
               ctrl_supply_on_ff <= 1'b0;
            end
         end
      end
   end

   // receive pin alert; limitation: the event delay timer is not modelled
   assign rxd_force_low = trx_offline & ctrl_supply_on_ff & any_pending;

   // =====================================================================
   // read path, registered so read data comes from flip-flops
   // =====================================================================
   always @* begin
      case (reg_addr)
         `ADDR_SYS_ENABLE:  nxt_rdata = sys_en_ff;
         `ADDR_SUP_ENABLE:  nxt_rdata = sup_en_ff;
         `ADDR_TRX_ENABLE:  nxt_rdata = trx_en_ff;
         `ADDR_WAKE_ENABLE: nxt_rdata = wake_en_ff;
         `ADDR_GLOBAL:      nxt_rdata = {4'h0, global_summary};
         `ADDR_SYS_FLAGS:   nxt_rdata = sys_flags_ff;
         `ADDR_SUP_FLAGS:   nxt_rdata = sup_flags_ff;
         `ADDR_TRX_FLAGS:   nxt_rdata = trx_flags_ff;
         `ADDR_WAKE_FLAGS:  nxt_rdata = wake_flags_ff;
         default:           nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_ff <= 8'h00;
      end else begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

endmodule // sbc_event_capture_sleep_guard

/* hdl/sbc_event_defines.vh */
// register offsets, field positions, reset values and codes of the event capture block
// assumes a single-clock host register port that has already decoded the serial frames
`ifndef SBC_EVENT_DEFINES_VH
`define SBC_EVENT_DEFINES_VH

// register offsets (7-bit register address)
`define ADDR_SYS_ENABLE    7'h04
`define ADDR_SUP_ENABLE    7'h1C
`define ADDR_TRX_ENABLE    7'h23
`define ADDR_WAKE_ENABLE   7'h4C
`define ADDR_GLOBAL        7'h60
`define ADDR_SYS_FLAGS     7'h61
`define ADDR_SUP_FLAGS     7'h62
`define ADDR_TRX_FLAGS     7'h63
`define ADDR_WAKE_FLAGS    7'h64

// system group bits
`define BIT_BATTERY_START  4
`define BIT_OVERHEAT       2
`define BIT_SERIAL_FAULT   1
`define BIT_WATCHDOG       0
// supply group bits
`define BIT_SENSOR_HIGH    2
`define BIT_SENSOR_LOW     1
`define BIT_CTRL_LOW       0
// transceiver group bits
`define BIT_FRAME_ERROR    5
`define BIT_BUS_SILENCE    4
`define BIT_BUS_FAULT      1
`define BIT_CAN_WAKE       0
// wake pin group bits
`define BIT_WAKE_RISE      1
`define BIT_WAKE_FALL      0
// global summary bits
`define BIT_SYS_PENDING    0
`define BIT_SUP_PENDING    1
`define BIT_TRX_PENDING    2
`define BIT_WAKE_PENDING   3

// writable masks of the enable registers
`define MASK_SYS_ENABLE    8'h06
`define MASK_SUP_ENABLE    8'h07
`define MASK_TRX_ENABLE    8'h13
`define MASK_WAKE_ENABLE   8'h03

// reset values
`define RST_ENABLE         8'h00
`define RST_FLAGS          8'h00

// operating mode command code that asks for sleep
`define MODE_CMD_SLEEP     3'h1

`endif

/* test/sbc_guard_checker.sv */
// concurrent checks on the ports of the event capture and sleep guard block
// assumes it is bound to the block and sees nothing but its ports
`timescale 1ns/1ps
module sbc_guard_checker (
   input wire       sys_clk,                 // block clock
   input wire       rst_b,                   // async reset, active low
   input wire [6:0] reg_addr,                // register address
   input wire [7:0] reg_rdata_ff,            // registered read data
   input wire       mode_cmd_valid,          // mode command strobe
   input wire [2:0] operating_mode_command,  // mode command code
   input wire       sleep_lockout_config,    // sleep lockout level
   input wire       watchdog_fail_event,     // watchdog failure pulse
   input wire       bus_active,              // bus activity level
   input wire       trx_offline,             // transceiver offline level
   input wire       rxd_force_low,           // pending event on receive pin
   input wire       sleep_mode_ff,           // sleep level
   input wire       ctrl_supply_on_ff,       // controller supply level
   input wire       reset_mode_req_ff,       // reset mode pulse
   input wire       system_reset_req_ff      // system reset pulse
);
   // ==========================================================================
   // helper: an unlocked sleep request, delayed to line up with the answer
   wire nxt_sleep_req = mode_cmd_valid && operating_mode_command == 3'h1 && !sleep_lockout_config;
   reg  sleep_req_ff;
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         sleep_req_ff <= 1'b0;
      else
         sleep_req_ff <= nxt_sleep_req;
   end
   // ==========================================================================
   // properties; a reset always cuts a check short
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_wake; $fell(sleep_mode_ff); endsequence
   sequence s_locked_cmd;
      mode_cmd_valid && operating_mode_command == 3'h1 && sleep_lockout_config; endsequence
   property p_sum_rsvd; $past(reg_addr) == 7'h60 |-> reg_rdata_ff[7:4] == 4'h0; endproperty
   a_sum_rsvd: assert property (p_sum_rsvd) else $error("summary upper bits set");
   property p_sys_rsvd; $past(reg_addr) == 7'h61 |->
      reg_rdata_ff[7:5] == 3'h0 && !reg_rdata_ff[3]; endproperty
   a_sys_rsvd: assert property (p_sys_rsvd) else $error("system flag spare bits set");
   property p_silence; bus_active && $past(bus_active) && reg_addr == 7'h63 |=>
      !reg_rdata_ff[4]; endproperty
   a_silence: assert property (p_silence) else $error("silence flag set on active bus");
   property p_watchdog; watchdog_fail_event && trx_offline && ctrl_supply_on_ff &&
      !mode_cmd_valid |=> rxd_force_low || !trx_offline; endproperty
   a_watchdog: assert property (p_watchdog) else $error("watchdog event not pending");
   property p_rxd; rxd_force_low |-> trx_offline && ctrl_supply_on_ff; endproperty
   a_rxd: assert property (p_rxd) else $error("receive pin low out of offline");
   property p_lock; s_locked_cmd and !sleep_mode_ff |=>
      !sleep_mode_ff && !reset_mode_req_ff && !system_reset_req_ff; endproperty
   a_lock: assert property (p_lock) else $error("locked sleep command acted");
   property p_enter; $rose(sleep_mode_ff) |-> sleep_req_ff && !ctrl_supply_on_ff; endproperty
   a_enter: assert property (p_enter) else $error("sleep entered without request");
   property p_wake; s_wake |-> ctrl_supply_on_ff && reset_mode_req_ff; endproperty
   a_wake: assert property (p_wake) else $error("wake not through reset mode");
   property p_sysrst; system_reset_req_ff |-> sleep_req_ff && !sleep_mode_ff; endproperty
   a_sysrst: assert property (p_sysrst) else $error("system reset without sleep request");
   property p_rstmode; reset_mode_req_ff |-> sleep_req_ff || $past(sleep_mode_ff); endproperty
   a_rstmode: assert property (p_rstmode) else $error("reset mode without cause");
endmodule // sbc_guard_checker

bind sbc_event_capture_sleep_guard sbc_guard_checker sbc_guard_checker_inst (
   .sys_clk, .rst_b, .reg_addr, .reg_rdata_ff, .mode_cmd_valid, .operating_mode_command,
   .sleep_lockout_config, .watchdog_fail_event, .bus_active, .trx_offline, .rxd_force_low,
   .sleep_mode_ff, .ctrl_supply_on_ff, .reset_mode_req_ff, .system_reset_req_ff);

/* test/sbc_host_model.sv */
// host controller model: register writes and reads, operating mode commands
// assumes the block samples its register port and command strobe on sys_clk
`timescale 1ns/1ps
module sbc_host_model (
   input  wire       sys_clk,                // block clock
   input  wire [7:0] reg_rdata_ff,           // read data from the block
   output reg  [6:0] reg_addr,               // register address
   output reg        reg_wr,                 // write strobe
   output reg  [7:0] reg_wdata,              // write data
   output reg        mode_cmd_valid,         // mode command strobe
   output reg  [2:0] operating_mode_command  // mode command code
);
   // ==========================================================================
   // idle port at time zero
   initial begin
      {reg_addr, reg_wr, reg_wdata, mode_cmd_valid, operating_mode_command} = 20'h00000;
   end
   // write of one cycle; a one in the data clears that flag, a zero keeps it
   task wr(input [6:0] a, input [7:0] d);
      begin
         @(posedge sys_clk);
         reg_addr <= a;
         reg_wr <= 1'b1;
         reg_wdata <= d;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
      end
   endtask
   // read data is registered, so it is taken just after the edge that loads it
   task rd(input [6:0] a, output [7:0] d);
      begin
         @(posedge sys_clk);
         reg_addr <= a;
         @(posedge sys_clk);
         #1 d = reg_rdata_ff;
      end
   endtask
   // one-cycle command; returns once the answering edge has landed
   task cmd(input [2:0] c);
      begin
         @(posedge sys_clk);
         mode_cmd_valid <= 1'b1;
         operating_mode_command <= c;
         @(posedge sys_clk);
         mode_cmd_valid <= 1'b0;
         #1;
      end
   endtask
endmodule // sbc_host_model

/* test/test_sbc_event_capture_sleep_guard.sv */
// self-checking bench of the event capture and sleep guard block
// assumes the host model drives the register port and the mode commands
`timescale 1ns/1ps
module test_sbc_event_capture_sleep_guard;
   reg         sys_clk, rst_b, sleep_lockout_config, bus_active, trx_offline, wake_pin;
   reg  [10:0] ev;                           // event pulses in port order
   wire [6:0]  reg_addr;                     // register address
   wire [7:0]  reg_wdata, reg_rdata_ff;      // register data
   wire [2:0]  operating_mode_command;       // mode code
   wire        reg_wr, mode_cmd_valid, rxd_force_low, sleep_mode_ff, ctrl_supply_on_ff;
   wire        reset_mode_req_ff, system_reset_req_ff;
   integer     errors, checks, i, n;
   reg  [7:0]  rv;                           // value read back
   reg  [47:0] rows [0:13];                  // event, enable addr, enable, flag addr, flag, summary
   // ==========================================================================
   sbc_event_capture_sleep_guard sbc_event_capture_sleep_guard_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .mode_cmd_valid(mode_cmd_valid),
      .operating_mode_command(operating_mode_command),
      .sleep_lockout_config(sleep_lockout_config), .off_mode_exit(ev[0]),
      .overheat_event(ev[1]), .serial_fail_event(ev[2]), .watchdog_fail_event(ev[3]),
      .sensor_high_event(ev[4]), .sensor_low_event(ev[5]), .ctrl_low_event(ev[6]),
      .frame_error_event(ev[7]), .silence_event(ev[8]), .bus_active(bus_active),
      .trx_deact_event(ev[9]), .can_wake_event(ev[10]), .trx_offline(trx_offline),
      .wake_pin(wake_pin), .rxd_force_low(rxd_force_low), .sleep_mode_ff(sleep_mode_ff),
      .ctrl_supply_on_ff(ctrl_supply_on_ff), .reset_mode_req_ff(reset_mode_req_ff),
      .system_reset_req_ff(system_reset_req_ff));
   sbc_host_model sbc_host_model_inst (
      .sys_clk(sys_clk), .reg_rdata_ff(reg_rdata_ff), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .mode_cmd_valid(mode_cmd_valid),
      .operating_mode_command(operating_mode_command));
   // ==========================================================================
   // 10 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // a stuck handshake must still reach the verdict
   initial begin
      #5000000;
      errors = errors + 1;
      tally_and_finish;
   end
   task check(input [8*16-1:0] what, input [7:0] seen, input [7:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", checks, errors);
         if (errors == 0 && checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // one-cycle event pulse on a source; index 11 and 12 move the wake pin instead
   task pulse(input integer k);
      begin
         @(posedge sys_clk);
         if (k == 11)
            wake_pin <= 1'b1;
         else if (k == 12)
            wake_pin <= 1'b0;
         else
            ev[k] <= 1'b1;
         @(posedge sys_clk);
         ev <= 11'h000;
      end
   endtask
   // ==========================================================================
   initial begin
      {rst_b, sleep_lockout_config, bus_active, wake_pin, ev} = 15'h0000;
      trx_offline = 1'b1;
      errors = 0;
      checks = 0;
      rows[0] = 48'h00_04_00_61_10_01;
      rows[1] = 48'h01_04_00_61_00_00;       // overheat with capture off stays clear
      rows[2] = 48'h01_04_04_61_04_01;
      rows[3] = 48'h02_04_02_61_02_01;
      rows[4] = 48'h03_04_00_61_01_01;
      rows[5] = 48'h04_1C_04_62_04_02;
      rows[6] = 48'h05_1C_02_62_02_02;
      rows[7] = 48'h06_1C_01_62_01_02;
      rows[8] = 48'h07_23_00_63_20_04;
      rows[9] = 48'h08_23_10_63_10_04;
      rows[10] = 48'h09_23_02_63_02_04;
      rows[11] = 48'h0A_23_01_63_01_04;
      rows[12] = 48'h0B_4C_03_64_02_08;
      rows[13] = 48'h0C_4C_03_64_01_08;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      sbc_host_model_inst.rd(7'h04, rv);
      check("enable reset", rv, 8'h00);
      sbc_host_model_inst.rd(7'h7F, rv);
      check("unmapped", rv, 8'h00);
      // table: enable, raise one source, read it, write zero, then clear it
      for (i = 0; i < 14; i = i + 1) begin
         sbc_host_model_inst.wr(rows[i][38:32], rows[i][31:24]);
         pulse(rows[i][47:40]);
         repeat (3) @(posedge sys_clk);
         sbc_host_model_inst.rd(rows[i][22:16], rv);
         check("flag", rv, rows[i][15:8]);
         check("rxd", {7'h00, rxd_force_low}, {7'h00, |rows[i][15:8]});
         sbc_host_model_inst.rd(7'h60, rv);
         check("summary", rv, rows[i][7:0]);
         sbc_host_model_inst.wr(rows[i][22:16], 8'h00);
         sbc_host_model_inst.rd(rows[i][22:16], rv);
         check("zero write", rv, rows[i][15:8]);
         sbc_host_model_inst.wr(rows[i][22:16], 8'hFF);
         sbc_host_model_inst.rd(7'h60, rv);
         check("cleared", rv, 8'h00);
         $display("row %0d done", i);
      end
      // silence flag drops as soon as the bus is active
      sbc_host_model_inst.wr(7'h23, 8'h11);
      pulse(8);
      bus_active <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sbc_host_model_inst.rd(7'h63, rv);
      check("silence active", rv, 8'h00);
      // locked sleep turns into a serial fault only
      sbc_host_model_inst.wr(7'h04, 8'h02);
      sleep_lockout_config <= 1'b1;
      sbc_host_model_inst.cmd(3'h1);
      check("locked", {5'h00, sleep_mode_ff, reset_mode_req_ff, system_reset_req_ff}, 8'h00);
      sbc_host_model_inst.rd(7'h61, rv);
      check("locked fault", rv, 8'h02);
      sbc_host_model_inst.wr(7'h61, 8'hFF);
      sleep_lockout_config <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         sbc_host_model_inst.cmd(i[2:0]);
         check("other code", {7'h00, sleep_mode_ff}, (i == 0) ? 8'h00 : 8'h01);
      end
      check("asleep", {6'h00, sleep_mode_ff, ctrl_supply_on_ff}, 8'h02);
      // a pending flag sends a sleep request to reset mode; a wake ends sleep
      pulse(10);
      for (n = 0; n < 20 && sleep_mode_ff === 1'b1; n = n + 1)
         @(posedge sys_clk);
      if (n == 20) begin
         errors = errors + 1;
         tally_and_finish;
      end
      check("awake", {6'h00, sleep_mode_ff, ctrl_supply_on_ff}, 8'h01);
      sbc_host_model_inst.cmd(3'h1);
      check("pending", {6'h00, sleep_mode_ff, reset_mode_req_ff}, 8'h01);
      sbc_host_model_inst.wr(7'h63, 8'hFF);
      // no regular wake source left: sleep becomes a system reset
      sbc_host_model_inst.wr(7'h23, 8'h00);
      sbc_host_model_inst.wr(7'h4C, 8'h00);
      sbc_host_model_inst.cmd(3'h1);
      check("no wake src", {6'h00, sleep_mode_ff, system_reset_req_ff}, 8'h01);
      $display("sleep guard tests done");
      tally_and_finish;
   end
endmodule // test_sbc_event_capture_sleep_guard
